// ===== testbench/spi_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// ***************************************************************
// Serial host driving the programming port
// ***************************************************************
module spi_host_model
   import descriptor_hid_serial_port_pkg::*;
(
   input wire logic clk_sys_i,
   output serial_pins_t serial_o
);
   // Shift clock half period in system clocks, 160 ns period
   localparam int HALF_CYC = 10;

   // Select idle high, clock parked low until a word starts
   initial begin
      serial_o = 3'h4;
   end

   // Step just past a clock edge
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask

   // One framed word, B15 first, sampled on rising shift clock
   task automatic send_word(input logic [15:0] word);
      send_bits(word, WORD_BITS);
   endtask

   // Frame of nbits clocks, bit nbits-1 first, down to B0
   task automatic send_bits(input logic [15:0] word, input int nbits);
      wait_cyc(1);
      serial_o.serial_select = 1'h0;
      for (int i = nbits - 1; i >= 0; i--) begin
         serial_o.serial_data_in = word[i];
         wait_cyc(HALF_CYC);
         serial_o.serial_shift_clock = 1'h1;
         wait_cyc(HALF_CYC);
         serial_o.serial_shift_clock = 1'h0;
      end
      wait_cyc(HALF_CYC);
      serial_o.serial_select = 1'h1;
      serial_o.serial_data_in = ~word[0]; // Released line driven to inverse of B0
      wait_cyc(3 * HALF_CYC);
   endtask

   // Descriptor byte, top nibble zero, D0 placed at B7
   task automatic send_byte(input logic [7:0] value);
      logic [15:0] word;
      word = 16'h0800;
      for (int k = 0; k < DATA_BITS; k++) begin
         word[7 - k] = value[k];
      end
      send_word(word);
   endtask
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
// ***************************************************************
// Programming port bench
// ***************************************************************
module tb_top
   import descriptor_hid_serial_port_pkg::*;
;
   logic clk_sys_i = 1'h0;
   logic rst_b_i = 1'h0;
   serial_pins_t serial_w;
   config_pins_t config_pins = 2'h0;
   logic [5:0] rd_index = 6'h00;
   hid_status_t hid_status;
   logic desc_done;
   logic desc_override;
   logic [15:0] rd_data;
   int err_count = 0;
   int num_checks = 0;
   int cycles = 0;

   // System clock, 8 ns
   always #4 clk_sys_i = ~clk_sys_i;

   // Device under test and serial host
   descriptor_hid_serial_port u_descriptor_hid_serial_port (
      .clk_sys_i(clk_sys_i),
      .rst_b_i(rst_b_i),
      .serial_i(serial_w),
      .config_i(config_pins),
      .rd_index_i(rd_index),
      .hid_status_o(hid_status),
      .desc_done_o(desc_done),
      .desc_override_o(desc_override),
      .rd_data_o(rd_data)
   );
   spi_host_model u_spi_host_model (
      .clk_sys_i(clk_sys_i),
      .serial_o(serial_w)
   );

   // Compare and count
   task automatic chk(input string what, input logic [15:0] exp,
         input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Verdict and end of run
   task automatic results();
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Step just past a clock edge
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask

   // Readback of one stored byte
   task automatic rd(input logic [5:0] idx, input logic [15:0] exp);
      rd_index = idx;
      tick(2);
      chk("rd_data", exp, rd_data);
   endtask

   // Image content with varied bits per byte
   function automatic logic [7:0] img(input int n);
      return 8'(n * 37 + 11);
   endfunction

   // Hang guard
   always @(posedge clk_sys_i) begin
      cycles++;
      if (cycles == 80000) begin
         err_count++;
         results();
      end
   end

   // Main sequence
   initial begin
      tick(8);
      rst_b_i = 1'h1;
      tick(4);
      chk("hid", 16'(HID_RESET), 16'(hid_status));
      chk("done", 16'h0001, 16'(desc_done));
      chk("override", 16'h0000, 16'(desc_override));
      // Each HID bit alone, D_k carried in B(7-k)
      for (int k = 0; k < DATA_BITS; k++) begin
         u_spi_host_model.send_word(16'(16'h0001 << (7 - k)));
         chk("hid", 16'(16'h0001 << k), 16'(hid_status));
      end
      // Short frame of 15 clocks leaves HID state alone
      u_spi_host_model.send_bits(16'h00ff, 15);
      chk("hid", 16'h0080, 16'(hid_status));
      // Pins low: pointer reset keeps its HID part only
      u_spi_host_model.send_word(16'h04a5);
      chk("hid", 16'h00a5, 16'(hid_status));
      chk("done", 16'h0001, 16'(desc_done));
      u_spi_host_model.send_byte(8'h3c);
      rd(6'h00, 16'h0000);
      // Pins high: full image after a pointer reset
      config_pins = 2'h3;
      tick(6);
      chk("override", 16'h0001, 16'(desc_override));
      u_spi_host_model.send_word(16'h0400);
      chk("hid", 16'h0000, 16'(hid_status));
      chk("done", 16'h0000, 16'(desc_done));
      chk("override", 16'h0000, 16'(desc_override));
      for (int n = 0; n < DESC_BYTES; n++) begin
         u_spi_host_model.send_byte(img(n));
         if (n == DESC_BYTES - 2) begin
            chk("done", 16'h0000, 16'(desc_done));
         end
      end
      chk("done", 16'h0001, 16'(desc_done));
      chk("override", 16'h0001, 16'(desc_override));
      u_spi_host_model.send_byte(8'hff);
      chk("done", 16'h0001, 16'(desc_done));
      for (int n = 0; n < DESC_BYTES; n++) begin
         rd(6'(n), {8'h00, img(n)});
      end
      rd(6'(DESC_BYTES), 16'h0000);
      // Host config pin low drops the override, stored image kept
      config_pins = 2'h2;
      tick(6);
      chk("override", 16'h0000, 16'(desc_override));
      // Mid-run reset clears HID state and store, sets counter to its end value
      u_spi_host_model.send_word(16'h0001);
      chk("hid", 16'h0080, 16'(hid_status));
      rst_b_i = 1'h0;
      tick(2);
      rst_b_i = 1'h1;
      tick(4);
      chk("hid", 16'(HID_RESET), 16'(hid_status));
      chk("done", 16'h0001, 16'(desc_done));
      rd(6'h00, 16'h0000);
      results();
   end
endmodule
`default_nettype wire

// ===== verilog/descriptor_hid_serial_port.sv
`timescale 1ns/100ps
`default_nettype none
module descriptor_hid_serial_port
   import descriptor_hid_serial_port_pkg::*;
#(
   parameter int NUM_BYTES = DESC_BYTES
) (
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   input wire serial_pins_t serial_i,
   input wire config_pins_t config_i,
   input wire logic [$clog2(NUM_BYTES+1)-1:0] rd_index_i,
   output hid_status_t hid_status_o,
   output logic desc_done_o,
   output logic desc_override_o,
   output logic [15:0] rd_data_o
);

   localparam int PTR_W = $clog2(NUM_BYTES + 1);
   localparam logic [PTR_W-1:0] PTR_END = PTR_W'(NUM_BYTES);
   localparam logic [4:0] BITS_FULL = 5'(WORD_BITS);

   // ************************************************************
   // Module state
   // ************************************************************
   typedef struct packed {
      logic sclk_q;
      logic sel_q;
      logic [WORD_BITS-1:0] shreg;
      logic [4:0] bits;
      logic [PTR_W-1:0] ptr;
      hid_status_t hid;
      logic [NUM_BYTES-1:0][7:0] mem;
      logic [15:0] rd_data;
      logic done;
      logic override;
   } state_t;

   state_t s;
   state_t next_s;
   serial_pins_t pins;
   config_pins_t cfg;
   logic sclk_rise;
   logic sel_rise;
   logic sel_fall;
   logic word_done;
   logic func_sel;
   logic ptr_rst;
   logic prog_en;
   logic [7:0] data_byte;

   // ************************************************************
   // Pin synchronisers
   // ************************************************************
   pin_sync #(
      .WIDTH(3),
      .RESET_VAL(3'h4)
   ) u_serial_sync (
      .clk_sys_i(clk_sys_i),
      .rst_b_i(rst_b_i),
      .async_i(serial_i),
      .sync_o(pins)
   );

   pin_sync #(
      .WIDTH(2),
      .RESET_VAL(2'h0)
   ) u_config_sync (
      .clk_sys_i(clk_sys_i),
      .rst_b_i(rst_b_i),
      .async_i(config_i),
      .sync_o(cfg)
   );

   // ************************************************************
   // Edge detection and word decode
   // ************************************************************
   // Edges of the synchronised select and clock
   assign sclk_rise = pins.serial_shift_clock & ~s.sclk_q;
   assign sel_rise = pins.serial_select & ~s.sel_q;
   assign sel_fall = ~pins.serial_select & s.sel_q;
   assign word_done = sel_rise && (s.bits == BITS_FULL);
   assign func_sel = s.shreg[FUNC_SEL_BIT];
   assign ptr_rst = s.shreg[PTR_RST_BIT];
   assign prog_en = cfg.power_select & cfg.host_config;

   // D0 sits in the word's bit 7, D7 in bit 0
   for (genvar i = 0; i < DATA_BITS; i++) begin : g_reverse
      assign data_byte[i] = s.shreg[DATA_BITS-1-i];
   end

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      next_s = s;
      next_s.sclk_q = pins.serial_shift_clock;
      next_s.sel_q = pins.serial_select;
      // Frame start clears the bit count
      if (sel_fall) begin
         next_s.bits = 5'h00;
      end else if (!pins.serial_select && sclk_rise) begin
         next_s.shreg = {s.shreg[WORD_BITS-2:0], pins.serial_data_in};
         if (s.bits != 5'h1f) begin
            next_s.bits = s.bits + 5'h01;
         end
      end
      if (word_done) begin
         if (!func_sel) begin
            next_s.hid = hid_status_t'(data_byte);
            if (ptr_rst && prog_en) begin
               next_s.ptr = '0;
            end
         end else if (!ptr_rst && prog_en && s.ptr < PTR_END) begin
            next_s.mem[s.ptr] = data_byte;
            next_s.ptr = s.ptr + PTR_W'(1);
         end
      end
      next_s.done = (next_s.ptr == PTR_END);
      next_s.override = prog_en && s.done;
      // Readback widened to a 16-bit Unicode code unit
      if (rd_index_i < PTR_END) begin
         next_s.rd_data = {8'h00, s.mem[rd_index_i]};
      end else begin
         next_s.rd_data = 16'h0000;
      end
   end

   // ************************************************************
   // State register
   // ************************************************************
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s <= '{
            sclk_q: 1'b0,
            sel_q: 1'b1,
            shreg: WORD_RESET,
            bits: 5'h00,
            ptr: PTR_END,
            hid: hid_status_t'(HID_RESET),
            mem: '0,
            rd_data: 16'h0000,
            done: 1'b1,
            override: 1'b0
         };
      end else begin
         s <= next_s;
      end
   end

   // Outputs straight from state
   assign hid_status_o = s.hid;
   assign desc_done_o = s.done;
   assign desc_override_o = s.override;
   assign rd_data_o = s.rd_data;

   // ************************************************************
   // Assertions
   // ************************************************************
   logic [7:0] rd_byte_now;
   assign rd_byte_now = (rd_index_i < PTR_END) ? s.mem[rd_index_i] : 8'h00;

   property p_hid_top;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      word_done && !func_sel |=>
         {s.hid.mute, s.hid.vol_up, s.hid.vol_down} == $past(data_byte[7:5]);
   endproperty
   a_hid_top: assert property (p_hid_top)
      else $error("mute/volume bits not taken from word");

   property p_hid_track;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      word_done && !func_sel |=>
         {s.hid.next_track, s.hid.prev_track} == $past(data_byte[4:3]);
   endproperty
   a_hid_track: assert property (p_hid_track)
      else $error("track bits not taken from word");

   property p_hid_low;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      word_done && !func_sel |=> ##1
         {hid_status_o.stop, hid_status_o.play_pause, hid_status_o.ext_cmd}
         == $past(data_byte[2:0], 2);
   endproperty
   a_hid_low: assert property (p_hid_low)
      else $error("stop/play/extended bits not taken from word");

   property p_hid_hold;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      !(word_done && !func_sel) |=> $stable(s.hid);
   endproperty
   a_hid_hold: assert property (p_hid_hold)
      else $error("HID state changed without HID word");

   property p_ptr_reset;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      word_done && !func_sel && ptr_rst && prog_en |=> s.ptr == '0;
   endproperty
   a_ptr_reset: assert property (p_ptr_reset)
      else $error("pointer reset word did not clear counter");

   property p_store;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      word_done && func_sel && !ptr_rst && prog_en && s.ptr < PTR_END
      |=> s.ptr == $past(s.ptr) + PTR_W'(1)
          && s.mem[$past(s.ptr)] == $past(data_byte);
   endproperty
   a_store: assert property (p_store)
      else $error("descriptor byte not stored or counter not advanced");

   property p_ptr_end;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      s.ptr == PTR_END && !(word_done && ptr_rst && !func_sel)
      |=> s.ptr == PTR_END && $stable(s.mem);
   endproperty
   a_ptr_end: assert property (p_ptr_end)
      else $error("write beyond final descriptor byte");

   property p_gated;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      !prog_en |=> $stable(s.ptr) && $stable(s.mem) && !desc_override_o;
   endproperty
   a_gated: assert property (p_gated)
      else $error("programming accepted while disabled");

   property p_unicode;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      1'b1 |=> rd_data_o == {8'h00, $past(rd_byte_now)};
   endproperty
   a_unicode: assert property (p_unicode)
      else $error("readback not widened from stored byte");

   property p_frame;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      sel_rise && s.bits != BITS_FULL |=> $stable(s.hid) && $stable(s.ptr);
   endproperty
   a_frame: assert property (p_frame)
      else $error("short or long frame acted upon");

   c_hid: cover property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      word_done && !func_sel);
   c_reset: cover property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      word_done && !func_sel && ptr_rst && prog_en);
   c_full: cover property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      $rose(desc_override_o));
   c_excess: cover property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      word_done && func_sel && s.ptr == PTR_END);

endmodule
`default_nettype wire

// ===== verilog/descriptor_hid_serial_port_pkg.sv
// ***************************************************************
// Shared constants and types
// ***************************************************************
package descriptor_hid_serial_port_pkg;

   // Command word layout
   localparam int WORD_BITS = 16;
   localparam int FUNC_SEL_BIT = 11;
   localparam int PTR_RST_BIT = 10;
   localparam int DATA_BITS = 8;

   // Descriptor image size in bytes
   localparam int DESC_BYTES = 57;

   // Serial clock figures, for reference by the bench
   localparam int CLK_PERIOD_NS = 8;
   localparam int SCLK_MIN_HIGH_NS = 50;
   localparam int SCLK_MIN_HIGH_CYC =
      (SCLK_MIN_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Reset values
   localparam logic [7:0] HID_RESET = 8'h00;
   localparam logic [15:0] WORD_RESET = 16'h0000;

   // HID state, field order matches D7 down to D0
   typedef struct packed {
      logic mute;
      logic vol_up;
      logic vol_down;
      logic next_track;
      logic prev_track;
      logic stop;
      logic play_pause;
      logic ext_cmd;
   } hid_status_t;

   // Serial port pins
   typedef struct packed {
      logic serial_select;
      logic serial_shift_clock;
      logic serial_data_in;
   } serial_pins_t;

   // Descriptor qualification pins
   typedef struct packed {
      logic power_select;
      logic host_config;
   } config_pins_t;

endpackage

// ===== verilog/pin_sync.sv
`timescale 1ns/100ps
`default_nettype none
// ***************************************************************
// Two-stage synchroniser for pins
// ***************************************************************
module pin_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] meta;

   // First stage feeds only the second
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         meta <= RESET_VAL;
         sync_o <= RESET_VAL;
      end else begin
         meta <= async_i;
         sync_o <= meta;
      end
   end

endmodule
`default_nettype wire
